/* File: fcs_defs.vh */
// Purpose: constants for the switch self-test sequencer
// Assumes: 125 MHz clock, synchronous active-high reset
// Notes:   status word bit positions, launch keys, timing counts
//
// Functional notes
// - Check-active high during test; blocks launches
// - Recovery flag one second after test
// - Undervolt below 45 V, clears above 46 V
// - Pass bit one, fail zero, after test
// - Launch with bits 0-5 set is rejected
// - Rejected flag cleared by successful launch
// - Loss below 36.9 V, clears above 38.4 V
// - Valid zero until first test completes
// - Test switches off FETs, samples node drop
// - Pass set if node dropped, else cleared
// - Status word is read-only to host
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// ---------------------------------------------------------------
// Status word bit positions
// ---------------------------------------------------------------
`define FCS_BIT_A_ACTIVE   0
`define FCS_BIT_B_ACTIVE   1
`define FCS_BIT_A_RECOVER  2
`define FCS_BIT_B_RECOVER  3
`define FCS_BIT_A_UV       4
`define FCS_BIT_B_UV       5
`define FCS_BIT_A_PASS     6
`define FCS_BIT_B_PASS     7
`define FCS_BIT_IGNORED    8
`define FCS_BIT_A_LOSS     9
`define FCS_BIT_B_LOSS     10
`define FCS_BIT_A_VALID    11
`define FCS_BIT_B_VALID    12
`define FCS_STATUS_RESET   16'h0000

// ---------------------------------------------------------------
// Launch keys
// ---------------------------------------------------------------
`define FCS_KEY_A_FIRST    8'h55
`define FCS_KEY_A_SECOND   8'hAA
`define FCS_KEY_B_FIRST    8'h56
`define FCS_KEY_B_SECOND   8'hAB

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
// Counts at 125 MHz, sized to the 28-bit timers: 1 s hold-off, 100 us off
`define FCS_RECOVER_CYC    28'h773_5940
`define FCS_OFF_CYC        28'h000_30D4

`endif

/* File: fcs_sequencer.v */
// Purpose: switch self-test sequencer with status word and launch key
// Assumes: host writes key bytes as single-cycle strobes
// Notes:   voltage thresholds arrive as comparator levels
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.vh"

module fcs_sequencer #(
   parameter [27:0] RECOVER_CYC = `FCS_RECOVER_CYC,
   parameter [27:0] OFF_CYC     = `FCS_OFF_CYC
) (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // Launch key register write port
   input  wire        i_key_wr,
   input  wire [7:0]  i_key_data,
   // Status word write strobe (ignored)
   input  wire        i_status_wr,
   input  wire [15:0] i_status_wdata,
   // Comparator inputs, per feed
   input  wire        i_feeda_below_45v,
   input  wire        i_feeda_above_46v,
   input  wire        i_feedb_below_45v,
   input  wire        i_feedb_above_46v,
   input  wire        i_feeda_below_36v9,
   input  wire        i_feeda_above_38v4,
   input  wire        i_feedb_below_36v9,
   input  wire        i_feedb_above_38v4,
   input  wire        i_feeda_node_dropped,
   input  wire        i_feedb_node_dropped,
   // Switch controls
   output reg         o_feeda_fet_off,
   output reg         o_feedb_fet_off,
   // Status word
   output wire [15:0] o_switch_selftest_status,
   output wire [7:0]  o_selftest_launch_key
);

   // ---------------------------------------------------------------
   // Comparator synchronisers
   // ---------------------------------------------------------------
   reg  [9:0]  sync1_reg;
   reg  [9:0]  sync2_reg;
   // Only the second stage feeds any flag
   always @(posedge i_clk) begin
      if (i_rst) begin
         sync1_reg <= 10'h000;
         sync2_reg <= 10'h000;
      end else begin
         sync1_reg <= {i_feedb_node_dropped, i_feeda_node_dropped,
                       i_feedb_above_38v4, i_feedb_below_36v9,
                       i_feeda_above_38v4, i_feeda_below_36v9,
                       i_feedb_above_46v, i_feedb_below_45v,
                       i_feeda_above_46v, i_feeda_below_45v};
         sync2_reg <= sync1_reg;
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_OFF     = 2'h1;
   localparam [1:0] ST_RECOVER = 2'h2;

   reg  [1:0]  st_a_reg, st_b_reg;
   reg  [27:0] cnt_a_reg, cnt_b_reg;
   reg         uv_a_reg, uv_b_reg, loss_a_reg, loss_b_reg;
   reg         pass_a_reg, pass_b_reg, valid_a_reg, valid_b_reg;
   reg         ignored_reg;
   reg  [7:0]  key_reg;
   reg         armed_a_reg, armed_b_reg;

   wire        act_a   = (st_a_reg == ST_OFF);
   wire        act_b   = (st_b_reg == ST_OFF);
   wire        rec_a   = (st_a_reg == ST_RECOVER);
   wire        rec_b   = (st_b_reg == ST_RECOVER);
   wire        busy    = act_a | act_b | rec_a | rec_b |
                         uv_a_reg | uv_b_reg;
   wire        req_a   = i_key_wr & armed_a_reg &
                         (i_key_data == `FCS_KEY_A_SECOND);
   wire        req_b   = i_key_wr & armed_b_reg &
                         (i_key_data == `FCS_KEY_B_SECOND);
   wire        go_a    = req_a & ~busy;
   wire        go_b    = req_b & ~busy;

   // ---------------------------------------------------------------
   // Status word assembly
   // ---------------------------------------------------------------
   // Reserved bits read zero; nothing here is host-writable
   reg  [15:0] status_word;
   always @* begin
      status_word                    = `FCS_STATUS_RESET;
      status_word[`FCS_BIT_A_ACTIVE]  = act_a;
      status_word[`FCS_BIT_B_ACTIVE]  = act_b;
      status_word[`FCS_BIT_A_RECOVER] = rec_a;
      status_word[`FCS_BIT_B_RECOVER] = rec_b;
      status_word[`FCS_BIT_A_UV]      = uv_a_reg;
      status_word[`FCS_BIT_B_UV]      = uv_b_reg;
      status_word[`FCS_BIT_A_PASS]    = pass_a_reg;
      status_word[`FCS_BIT_B_PASS]    = pass_b_reg;
      status_word[`FCS_BIT_IGNORED]   = ignored_reg;
      status_word[`FCS_BIT_A_LOSS]    = loss_a_reg;
      status_word[`FCS_BIT_B_LOSS]    = loss_b_reg;
      status_word[`FCS_BIT_A_VALID]   = valid_a_reg;
      status_word[`FCS_BIT_B_VALID]   = valid_b_reg;
   end
   assign o_switch_selftest_status = status_word;
   assign o_selftest_launch_key    = key_reg;

   // Hysteresis holds until the opposite threshold is crossed
   always @(posedge i_clk) begin
      if (i_rst) begin
         uv_a_reg   <= 1'b0;
         uv_b_reg   <= 1'b0;
         loss_a_reg <= 1'b0;
         loss_b_reg <= 1'b0;
      end else begin
         if (sync2_reg[0]) uv_a_reg <= 1'b1;
         else if (sync2_reg[1]) uv_a_reg <= 1'b0;
         if (sync2_reg[2]) uv_b_reg <= 1'b1;
         else if (sync2_reg[3]) uv_b_reg <= 1'b0;
         if (sync2_reg[4]) loss_a_reg <= 1'b1;
         else if (sync2_reg[5]) loss_a_reg <= 1'b0;
         if (sync2_reg[6]) loss_b_reg <= 1'b1;
         else if (sync2_reg[7]) loss_b_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Launch key decode
   // ---------------------------------------------------------------
   // Any write that is not the first byte disarms, so only the pair counts
   always @(posedge i_clk) begin
      if (i_rst) begin
         key_reg     <= 8'h00;
         armed_a_reg <= 1'b0;
         armed_b_reg <= 1'b0;
         ignored_reg <= 1'b0;
      end else if (i_key_wr) begin
         key_reg     <= i_key_data;
         armed_a_reg <= (i_key_data == `FCS_KEY_A_FIRST);
         armed_b_reg <= (i_key_data == `FCS_KEY_B_FIRST);
         if ((req_a | req_b) & busy) ignored_reg <= 1'b1;
         else if (go_a | go_b) ignored_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Per-feed sequencers
   // ---------------------------------------------------------------
   // Shared down-count step for both feeds' timers
   function [27:0] fcs_dec;
      input [27:0] val;
      begin
         fcs_dec = val - 28'h000_0001;
      end
   endfunction

   // Timers load count minus one so each phase lasts the full count
   // Status writes are deliberately unused: the word is read-only
   always @(posedge i_clk) begin
      if (i_rst) begin
         st_a_reg <= ST_IDLE;
         st_b_reg <= ST_IDLE;
         cnt_a_reg <= 28'h000_0000;
         cnt_b_reg <= 28'h000_0000;
         o_feeda_fet_off <= 1'b0;
         o_feedb_fet_off <= 1'b0;
         pass_a_reg  <= 1'b0;
         pass_b_reg  <= 1'b0;
         valid_a_reg <= 1'b0;
         valid_b_reg <= 1'b0;
      end else begin
         case (st_a_reg)
            ST_IDLE: begin
               if (go_a) begin
                  st_a_reg        <= ST_OFF;
                  o_feeda_fet_off <= 1'b1;
                  cnt_a_reg       <= fcs_dec(OFF_CYC);
               end
            end
            ST_OFF: begin
               if (cnt_a_reg == 28'h000_0000) begin
                  pass_a_reg      <= sync2_reg[8];
                  valid_a_reg     <= 1'b1;
                  o_feeda_fet_off <= 1'b0;
                  st_a_reg        <= ST_RECOVER;
                  cnt_a_reg       <= fcs_dec(RECOVER_CYC);
               end else cnt_a_reg <= fcs_dec(cnt_a_reg);
            end
            ST_RECOVER: begin
               if (cnt_a_reg == 28'h000_0000) st_a_reg <= ST_IDLE;
               else cnt_a_reg <= fcs_dec(cnt_a_reg);
            end
            default: st_a_reg <= ST_IDLE;
         endcase
         case (st_b_reg)
            ST_IDLE: begin
               if (go_b) begin
                  st_b_reg        <= ST_OFF;
                  o_feedb_fet_off <= 1'b1;
                  cnt_b_reg       <= fcs_dec(OFF_CYC);
               end
            end
            ST_OFF: begin
               if (cnt_b_reg == 28'h000_0000) begin
                  pass_b_reg      <= sync2_reg[9];
                  valid_b_reg     <= 1'b1;
                  o_feedb_fet_off <= 1'b0;
                  st_b_reg        <= ST_RECOVER;
                  cnt_b_reg       <= fcs_dec(RECOVER_CYC);
               end else cnt_b_reg <= fcs_dec(cnt_b_reg);
            end
            ST_RECOVER: begin
               if (cnt_b_reg == 28'h000_0000) st_b_reg <= ST_IDLE;
               else cnt_b_reg <= fcs_dec(cnt_b_reg);
            end
            default: st_b_reg <= ST_IDLE;
         endcase
      end
   end

endmodule // fcs_sequencer
`default_nettype wire

/* File: fcs_sequencer_monitor.sv */
// Purpose: port assertions for the switch self-test sequencer
// Assumes: short OFF_CYC and RECOVER_CYC counts in simulation
// Notes:   status flags lag comparator levels by three cycles
`timescale 1ns/1ps
`default_nettype none
module fcs_monitor #(parameter int OFF_CYC = 10, parameter int RECOVER_CYC = 50) (
   input wire logic        i_clk, i_rst, i_key_wr, i_status_wr,
   input wire logic [7:0]  i_key_data, o_selftest_launch_key,
   input wire logic [15:0] i_status_wdata, o_switch_selftest_status,
   input wire logic        i_feeda_below_45v, i_feeda_above_46v, i_feedb_below_45v,
   input wire logic        i_feedb_above_46v, i_feeda_below_36v9, i_feeda_above_38v4,
   input wire logic        i_feedb_below_36v9, i_feedb_above_38v4,
   input wire logic        i_feeda_node_dropped, i_feedb_node_dropped,
   input wire logic        o_feeda_fet_off, o_feedb_fet_off
);
   localparam int OFF_LO = OFF_CYC - 1;
   localparam int OFF_HI = OFF_CYC + 1;
   localparam int REC_LO = RECOVER_CYC - 1;
   localparam int REC_HI = RECOVER_CYC + 1;
   wire [15:0] s = o_switch_selftest_status;
   wire [7:0]  k = o_selftest_launch_key;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_pair_a;
      i_key_wr && i_key_data == 8'hAA && k == 8'h55;
   endsequence
   sequence s_pair_any;
      i_key_wr && (i_key_data == 8'hAA && k == 8'h55 || i_key_data == 8'hAB && k == 8'h56);
   endsequence
   sequence s_test_end;
      $fell(s[0]);
   endsequence
   a_launch_a: assert property
      (s_pair_a ##0 s[5:0] == 6'h00 |=> s[0] && o_feeda_fet_off && !s[8])
      else $error("launch A missed");
   a_reject_sets: assert property
      (s_pair_any ##0 s[5:0] != 6'h00 |=> s[8]) else $error("rejected launch not flagged");
   a_ignored_kept: assert property
      ($fell(s[8]) |-> $rose(s[0]) || $rose(s[1])) else $error("ignored flag cleared early");
   a_end_together: assert property
      (s_test_end |-> s[2] && s[11] && !o_feeda_fet_off) else $error("test end not aligned");
   a_active_len: assert property
      ($rose(s[0]) |-> ##[OFF_LO:OFF_HI] s_test_end) else $error("test length wrong");
   a_recover_len: assert property
      ($rose(s[2]) |-> ##[REC_LO:REC_HI] $fell(s[2])) else $error("recovery length wrong");
   a_pass_latch: assert property
      (s_test_end |-> s[6] == $past(i_feeda_node_dropped, 3)) else $error("pass bit wrong");
   a_uv_set: assert property
      ($rose(s[4]) |-> $past(i_feeda_below_45v, 3)) else $error("undervolt set wrongly");
   a_uv_clear: assert property
      ($fell(s[4]) |-> $past(i_feeda_above_46v, 3)) else $error("undervolt cleared wrongly");
   a_loss_move: assert property
      ($changed(s[9]) |-> $past(s[9] ? i_feeda_above_38v4 : i_feeda_below_36v9, 3))
      else $error("loss flag moved wrongly");
   a_valid_sticky: assert property
      (!$fell(s[11]) && !$fell(s[12])) else $error("valid flag dropped");
   a_one_feed: assert property
      (!(s[0] && s[1])) else $error("both feeds testing");
endmodule  // fcs_monitor
bind fcs_sequencer fcs_monitor #(.OFF_CYC(OFF_CYC), .RECOVER_CYC(RECOVER_CYC))
   fcs_monitor_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_key_wr(i_key_wr), .i_status_wr(i_status_wr),
   .i_key_data(i_key_data), .o_selftest_launch_key(o_selftest_launch_key),
   .i_status_wdata(i_status_wdata), .o_switch_selftest_status(o_switch_selftest_status),
   .i_feeda_below_45v(i_feeda_below_45v), .i_feeda_above_46v(i_feeda_above_46v),
   .i_feedb_below_45v(i_feedb_below_45v), .i_feedb_above_46v(i_feedb_above_46v),
   .i_feeda_below_36v9(i_feeda_below_36v9), .i_feeda_above_38v4(i_feeda_above_38v4),
   .i_feedb_below_36v9(i_feedb_below_36v9), .i_feedb_above_38v4(i_feedb_above_38v4),
   .i_feeda_node_dropped(i_feeda_node_dropped),
   .i_feedb_node_dropped(i_feedb_node_dropped),
   .o_feeda_fet_off(o_feeda_fet_off), .o_feedb_fet_off(o_feedb_fet_off));
`default_nettype wire

/* File: fcs_host_model.sv */
// Purpose: host model writing launch keys and status pokes
// Assumes: one strobe per byte, driven just after the rising edge
// Notes:   released data shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model (
   input  wire logic        i_clk,
   output var  logic        o_key_wr = 1'b0,
   output var  logic [7:0]  o_key_data = 8'h00,
   output var  logic        o_status_wr = 1'b0,
   output var  logic [15:0] o_status_wdata = 16'h0000
);
   task automatic put_key(input logic [7:0] b, input int gap);
      repeat (gap) @(posedge i_clk);
      @(posedge i_clk);
      o_key_wr   <= 1'b1;
      o_key_data <= b;
      @(posedge i_clk);
      o_key_wr   <= 1'b0;
      o_key_data <= ~b;
   endtask
   // Gap lets the bench act as a slow host
   task automatic send_pair(input logic [7:0] b0, b1, input int gap);
      put_key(b0, 0);
      put_key(b1, gap);
   endtask
   task automatic poke_status(input logic [15:0] v);
      @(posedge i_clk);
      o_status_wr    <= 1'b1;
      o_status_wdata <= v;
      @(posedge i_clk);
      o_status_wr    <= 1'b0;
      o_status_wdata <= ~v;
   endtask
endmodule  // fcs_host_model
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for the switch self-test sequencer
// Assumes: OFF 10 and REC 50 cycles stand in for 100 us and 1 s
// Notes:   node-drop levels held fixed, so feed outcomes are planned
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [27:0] OFF = 28'h00A;
   localparam logic [27:0] REC = 28'h032;
   logic i_clk = 1'b0, i_rst = 1'b1, adrop = 1'b1, bdrop = 1'b0;
   logic a45 = 1'b0, a46 = 1'b1, b45 = 1'b0, b46 = 1'b1;
   logic a36 = 1'b0, a38 = 1'b1, b36 = 1'b0, b38 = 1'b1;
   wire logic key_wr, st_wr, fet_a, fet_b;
   wire logic [7:0] key_d, key_q;
   wire logic [15:0] st_wd, st;
   int n_fail = 0, num_checks = 0, cyc = 0, n;
   always #4 i_clk = ~i_clk;
   fcs_host_model fcs_host_model_inst (.i_clk(i_clk), .o_key_wr(key_wr), .o_key_data(key_d),
      .o_status_wr(st_wr), .o_status_wdata(st_wd));
   fcs_sequencer #(.RECOVER_CYC(REC), .OFF_CYC(OFF)) fcs_sequencer_inst (.i_clk(i_clk),
      .i_rst(i_rst), .i_key_wr(key_wr), .i_key_data(key_d), .i_status_wr(st_wr),
      .i_status_wdata(st_wd), .i_feeda_below_45v(a45), .i_feeda_above_46v(a46),
      .i_feedb_below_45v(b45), .i_feedb_above_46v(b46), .i_feeda_below_36v9(a36),
      .i_feeda_above_38v4(a38), .i_feedb_below_36v9(b36), .i_feedb_above_38v4(b38),
      .i_feeda_node_dropped(adrop), .i_feedb_node_dropped(bdrop), .o_feeda_fet_off(fet_a),
      .o_feedb_fet_off(fet_b), .o_switch_selftest_status(st), .o_selftest_launch_key(key_q));
   task automatic chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t status mismatch got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_bit(input int b, input logic v);
      n = 0;
      do begin @(negedge i_clk); n++; end while (st[b] !== v && n < 200);
      chk(st[b], v);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_pass_a;
      fcs_host_model_inst.send_pair(8'h55, 8'hAA, 0);
      @(negedge i_clk);
      chk({st[1:0], fet_a}, 3'b011);
      fcs_host_model_inst.send_pair(8'h56, 8'hAB, 0);
      @(negedge i_clk);
      chk({st[8], st[1]}, 2'b10);
      wait_bit(0, 1'b0);
      chk({st[11], st[6], st[2], fet_a}, 4'b1110);
      fcs_host_model_inst.send_pair(8'h55, 8'hAA, 3);
      @(negedge i_clk);
      chk(st[0], 1'b0);
      wait_bit(2, 1'b0);
      chk(n > REC - 12 && n < REC - 4, 1'b1);
      $display("test pass_a done");
   endtask
   task automatic t_fail_b;
      fcs_host_model_inst.send_pair(8'h56, 8'hAB, 4);
      @(negedge i_clk);
      chk({st[8], st[1], fet_b}, 3'b011);
      wait_bit(1, 1'b0);
      chk({st[12], st[7], st[3]}, 3'b101);
      wait_bit(3, 1'b0);
      $display("test fail_b done");
   endtask
   task automatic t_order;
      fcs_host_model_inst.put_key(8'h55, 0);
      fcs_host_model_inst.send_pair(8'h00, 8'hAA, 0);
      fcs_host_model_inst.send_pair(8'h55, 8'hAB, 2);
      @(negedge i_clk);
      chk({st[8], st[1:0], key_q}, 11'h0AB);
      $display("test order done");
   endtask
   task automatic t_levels;
      @(posedge i_clk);
      {a45, b45, a46, b46, a36, b36, a38, b38} <= 8'hCC;
      repeat (5) @(negedge i_clk);
      chk({st[10:9], st[5:4]}, 4'hF);
      fcs_host_model_inst.send_pair(8'h55, 8'hAA, 0);
      @(negedge i_clk);
      chk({st[8], st[0]}, 2'b10);
      @(posedge i_clk);
      {a36, b36} <= 2'b00;
      repeat (5) @(negedge i_clk);
      chk({st[10:9], st[5:4]}, 4'hF);
      @(posedge i_clk);
      {a38, b38, a45, b45} <= 4'hC;
      repeat (5) @(negedge i_clk);
      chk({st[10:9], st[5:4]}, 4'h3);
      @(posedge i_clk);
      {a46, b46} <= 2'b11;
      repeat (5) @(negedge i_clk);
      chk(st[5:4], 2'b00);
      $display("test levels done");
   endtask
   task automatic t_ro;
      fcs_host_model_inst.poke_status(16'hFFFF);
      @(negedge i_clk);
      chk(st, 16'h1940);
      $display("test read_only done");
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      chk(st, 16'h0000);
      chk({8'h00, key_q}, 16'h0000);
      i_rst <= 1'b0;
      @(negedge i_clk);
      chk(st, 16'h0000);
      t_pass_a;
      t_fail_b;
      t_order;
      t_levels;
      t_ro;
      tally_and_finish;
   end
endmodule  // tb_top
`default_nettype wire
